/* tcg_defs.svh */
// Purpose: constants of the timer clock generator and interval timer
// Assumes: included by bare name; values used by tcg_top only
// Notes: register indexes are word indexes, byte address is four times the index
// Function
// RULE_01: tick source codes fast, external, slow, capture
// RULE_02: tick prescaler divides by one to four
// RULE_03: capture prescaler divides by two to eight
// RULE_04: capture source fast, external, slow, or stopped
// RULE_05: external means crystal if enabled, else pin
// RULE_06: twelve-bit down counter loaded from reload
// RULE_07: tick after zero is spent reloading
// RULE_08: interrupt request on every reload
// RULE_09: reload readable and writable while counting
// RULE_10: reset config gives 4 MHz and 1 us
// RULE_11: 1024 us timebase counts capture ticks
// RULE_12: software switches sources only while both run
// RULE_13: fast trim offset bits weight 7.5/15/30 kHz
// RULE_14: five-bit gain sets offset step size
// RULE_15: boot code loads trim calibration values
// RULE_16: crystal trim holds gm field and mode
// RULE_17: software uses gm 001 or 011 only
// RULE_18: slow trim bit 7 selects low power
// RULE_19: slow bias 00 mid, 01 high, 10 barred
// RULE_20: slow trim bits 3:0 set frequency
// RULE_21: sleep forces cpu select internal, stops oscillator
// RULE_22: fast oscillator ready three slow cycles later
// RULE_23: software reselects external clock after wake
// RULE_24: selection changes never truncate a tick
// RULE_25: cpu select 0 internal, 1 external
// RULE_26: crystal enable steers external input path
`ifndef TCG_DEFS_SVH
`define TCG_DEFS_SVH

// register word indexes
`define TCG_IDX_CPU_SEL 6'h30
`define TCG_IDX_CFG 6'h31
`define TCG_IDX_CLKIO 6'h32
`define TCG_IDX_FTRIM 6'h34
`define TCG_IDX_XTRIM 6'h35
`define TCG_IDX_STRIM 6'h36
`define TCG_IDX_RLD_LO 6'h38
`define TCG_IDX_RLD_HI 6'h39
`define TCG_IDX_CNT_LO 6'h3a
`define TCG_IDX_CNT_HI 6'h3b

// reset values
`define TCG_CFG_RST 8'h8f
`define TCG_TRIM_RST 8'h00
`define TCG_RLD_RST 12'h000

// source select codes
`define TCG_SRC_FAST 2'h0
`define TCG_SRC_EXT 2'h1
`define TCG_SRC_SLOW 2'h2
`define TCG_SRC_CAP 2'h3
`define TCG_BIAS_BARRED 2'h2

// oscillator input bit positions in the sync vector
`define TCG_OSC_FAST 0
`define TCG_OSC_SLOW 1
`define TCG_OSC_XTAL 2
`define TCG_OSC_PIN 3
`define TCG_OSC_N 4

// synchroniser plus edge stage depth
`define TCG_SYNC_STAGES 3

// timebase: 1024 us at the nominal 4 MHz capture rate
`define TCG_TIMEBASE_US 1024
`define TCG_CAP_NOM_MHZ 4
`define TCG_TB_LAST 12'(`TCG_TIMEBASE_US * `TCG_CAP_NOM_MHZ - 1)

// fast oscillator recovery: three slow oscillator cycles
`define TCG_RECOVER_LAST 2'h2

`endif

/* tcg_pkg.sv */
// Purpose: types of the timer clock generator
// Assumes: imported whole by tcg_top
// Notes: constants live in tcg_defs.svh
package tcg_pkg;
	// fast oscillator life cycle around sleep
	typedef enum logic [1:0] {FOSC_RUN, FOSC_STOPPED, FOSC_RECOVER} tcg_fosc_state_t;
endpackage

/* tcg_top.sv */
// Purpose: timer clock sources, prescalers, interval timer, oscillator trims, sleep fallback
// Assumes: oscillator waveforms arrive asynchronously and are far slower than REF_CLK
// Notes: every derived clock is a one-cycle enable pulse on REF_CLK
`timescale 1ns/100ps
`include "tcg_defs.svh"
module tcg_top import tcg_pkg::*; (
	input wire logic REF_CLK, // 250 MHz system clock
	input wire logic RST, // synchronous reset, active high
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb access phase
	input wire logic PWRITE, // apb direction, high for write
	input wire logic [7:0] PADDR, // apb byte address
	input wire logic [31:0] PWDATA, // apb write data
	output logic [31:0] PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error on unmapped address
	input wire logic FAST_OSC_IN, // internal 24 MHz oscillator waveform
	input wire logic SLOW_OSC_IN, // internal 32 kHz oscillator waveform
	input wire logic XTAL_OSC_IN, // crystal oscillator output
	input wire logic EXT_CLK_PIN, // raw external clock pin input
	input wire logic SLEEP_REQ, // processor sleep state, level
	output logic CAPTURE_TICK, // capture base clock enable pulse
	output logic INTERVAL_TICK, // interval tick clock enable pulse
	output logic TIMEBASE_TICK, // 1024 us timebase pulse
	output logic INTERVAL_IRQ, // interrupt pulse on reload
	output logic CPU_CLK_SEL, // processor clock select, 1 external
	output logic XTAL_EN, // crystal oscillator enable
	output logic FAST_OSC_EN, // fast oscillator run enable
	output logic FAST_OSC_READY, // fast oscillator recovered
	output logic [2:0] FAST_TRIM_OFFSET, // fast oscillator fine offset
	output logic [4:0] FAST_TRIM_GAIN, // fast oscillator offset gain
	output logic [2:0] XTAL_GM, // crystal amplifier transconductance
	output logic XTAL_TEST_MODE, // crystal fixed maximum bias mode
	output logic SLOW_LOW_POWER, // slow oscillator low power mode
	output logic [1:0] SLOW_BIAS, // slow oscillator bias, 00 mid, 01 high
	output logic [3:0] SLOW_FREQ_TRIM // slow oscillator frequency trim
);

	// oscillator synchronisers and edge detection
	logic [`TCG_OSC_N-1:0] osc_s1_q; // first stage, read only by second
	logic [`TCG_OSC_N-1:0] osc_s2_q; // second stage
	logic [`TCG_OSC_N-1:0] osc_s3_q; // previous level for edge detect
	logic [`TCG_OSC_N-1:0] osc_edge; // one pulse per rising edge
	logic [`TCG_SYNC_STAGES-1:0] sync_fill_q; // ones walk in after reset

	// registers
	logic [7:0] cfg_q; // timer clock configuration
	logic cpu_sel_q; // processor clock select
	logic xtal_en_q; // crystal enable
	logic [7:0] ftrim_q; // fast oscillator trim
	logic [2:0] xgm_q; // crystal transconductance
	logic xmode_q; // crystal mode
	logic slow_lp_q; // slow low power
	logic [1:0] slow_bias_q; // slow bias
	logic [3:0] slow_freq_q; // slow frequency trim
	logic [11:0] reload_q; // interval reload value
	logic [11:0] ival_cnt_q; // interval down counter

	// bus signals
	logic [5:0] idx; // word index
	logic access; // completing access phase
	logic wr_en; // write takes effect now
	logic [7:0] rd_data; // read mux
	logic rd_err; // address is unmapped
	logic pready_q; // registered ready
	logic [31:0] prdata_q; // registered read data
	logic pslverr_q; // registered error

	// clock generation
	logic ext_edge; // external source pulse
	logic cap_src; // selected capture source pulse
	logic itk_src; // selected interval source pulse
	logic [2:0] cap_div_cnt_q; // capture prescaler count
	logic [2:0] cap_last; // capture prescaler terminal count
	logic [1:0] itk_div_cnt_q; // interval prescaler count
	logic cap_tick_q; // capture tick pulse
	logic itk_tick_q; // interval tick pulse
	logic irq_q; // reload interrupt pulse
	logic [11:0] tb_cnt_q; // timebase counter
	logic tb_tick_q; // timebase pulse
	logic cfg_wr; // configuration written

	// sleep handling
	tcg_fosc_state_t fosc_q; // fast oscillator state
	logic [1:0] rec_cnt_q; // slow edges seen during recovery
	logic fosc_en_q; // fast oscillator enable
	logic fosc_rdy_q; // fast oscillator ready

	// the edge stage starts from a reset value, not a real sample; a pin that
	// is high at release would look like a rising edge, so edges wait until
	// every stage holds a real sample
	always_ff @(posedge REF_CLK) begin
		if (RST)
			sync_fill_q <= '0;
		else
			sync_fill_q <= {sync_fill_q[`TCG_SYNC_STAGES-2:0], 1'b1};
	end

	// two flops before any logic, then a third for the edge
	genvar g;
	generate
		for (g = 0; g < `TCG_OSC_N; g++) begin : g_sync
			always_ff @(posedge REF_CLK) begin
				if (RST) begin
					osc_s1_q[g] <= 1'b0;
					osc_s2_q[g] <= 1'b0;
					osc_s3_q[g] <= 1'b0;
				end else begin
					osc_s1_q[g] <= g == `TCG_OSC_FAST ? FAST_OSC_IN :
						g == `TCG_OSC_SLOW ? SLOW_OSC_IN :
						g == `TCG_OSC_XTAL ? XTAL_OSC_IN : EXT_CLK_PIN;
					osc_s2_q[g] <= osc_s1_q[g];
					osc_s3_q[g] <= osc_s2_q[g];
				end
			end
			assign osc_edge[g] = osc_s2_q[g] & ~osc_s3_q[g] & sync_fill_q[`TCG_SYNC_STAGES-1];
		end
	endgenerate

	// apb decode: zero wait states, ready rises in the access phase
	assign idx = PADDR[7:2];
	assign access = PSEL & PENABLE & pready_q;
	assign wr_en = access & PWRITE & ~rd_err;
	assign cfg_wr = wr_en & (idx == `TCG_IDX_CFG);

	// read mux, reserved bits read zero
	always_comb begin
		rd_data = 8'h00;
		rd_err = 1'b0;
		case (idx)
			`TCG_IDX_CPU_SEL: rd_data = {7'h00, cpu_sel_q};
			`TCG_IDX_CFG: rd_data = cfg_q;
			`TCG_IDX_CLKIO: rd_data = {4'h0, xtal_en_q, 3'h0};
			`TCG_IDX_FTRIM: rd_data = ftrim_q;
			`TCG_IDX_XTRIM: rd_data = {3'h0, xgm_q, 1'b0, xmode_q};
			`TCG_IDX_STRIM: rd_data = {slow_lp_q, 1'b0, slow_bias_q, slow_freq_q};
			`TCG_IDX_RLD_LO: rd_data = reload_q[7:0]; // RULE_09
			`TCG_IDX_RLD_HI: rd_data = {4'h0, reload_q[11:8]}; // RULE_09
			`TCG_IDX_CNT_LO: rd_data = ival_cnt_q[7:0];
			`TCG_IDX_CNT_HI: rd_data = {4'h0, ival_cnt_q[11:8]};
			default: rd_err = 1'b1; // unmapped answers with an error
		endcase
	end

	// bus answer flops, loaded in the setup cycle
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= PSEL & ~PENABLE;
			if (PSEL & ~PENABLE) begin
				prdata_q <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_data};
				pslverr_q <= rd_err;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// configuration and processor select registers
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			cfg_q <= `TCG_CFG_RST; // RULE_10
			cpu_sel_q <= 1'b0;
			xtal_en_q <= 1'b0;
		end else begin
			if (cfg_wr)
				cfg_q <= PWDATA[7:0];
			// sleep overrides any select write in the same cycle
			if (SLEEP_REQ)
				cpu_sel_q <= 1'b0; // RULE_21
			else if (wr_en && idx == `TCG_IDX_CPU_SEL)
				cpu_sel_q <= PWDATA[0]; // RULE_25
			if (wr_en && idx == `TCG_IDX_CLKIO)
				xtal_en_q <= PWDATA[3]; // RULE_26
		end
	end

	// trim registers: reset to zero here, boot code must load calibration
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ftrim_q <= `TCG_TRIM_RST; // RULE_15
			xgm_q <= 3'h0;
			xmode_q <= 1'b0;
			slow_lp_q <= 1'b0;
			slow_bias_q <= 2'h0;
			slow_freq_q <= 4'h0;
		end else if (wr_en) begin
			if (idx == `TCG_IDX_FTRIM)
				ftrim_q <= PWDATA[7:0]; // RULE_13 RULE_14
			if (idx == `TCG_IDX_XTRIM) begin
				xgm_q <= PWDATA[4:2]; // RULE_16
				xmode_q <= PWDATA[0]; // RULE_16
			end
			if (idx == `TCG_IDX_STRIM) begin
				slow_lp_q <= PWDATA[7]; // RULE_18
				slow_freq_q <= PWDATA[3:0]; // RULE_20
				// the barred bias code would stall the oscillator, keep the old one
				if (PWDATA[5:4] != `TCG_BIAS_BARRED)
					slow_bias_q <= PWDATA[5:4]; // RULE_19
			end
		end
	end

	// reload register, bytes written separately while counting
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			reload_q <= `TCG_RLD_RST;
		end else if (wr_en) begin
			if (idx == `TCG_IDX_RLD_LO)
				reload_q[7:0] <= PWDATA[7:0]; // RULE_09
			if (idx == `TCG_IDX_RLD_HI)
				reload_q[11:8] <= PWDATA[3:0]; // RULE_09
		end
	end

	// external source: crystal while enabled, else the raw pin
	assign ext_edge = xtal_en_q ? osc_edge[`TCG_OSC_XTAL] : osc_edge[`TCG_OSC_PIN]; // RULE_05 RULE_26

	// capture source select, code 11 stops the clock
	always_comb begin
		case (cfg_q[5:4])
			`TCG_SRC_FAST: cap_src = osc_edge[`TCG_OSC_FAST]; // RULE_04
			`TCG_SRC_EXT: cap_src = ext_edge; // RULE_04
			`TCG_SRC_SLOW: cap_src = osc_edge[`TCG_OSC_SLOW]; // RULE_04
			`TCG_SRC_CAP: cap_src = 1'b0; // RULE_04
		endcase
	end

	// interval source select, code 11 takes the capture tick
	always_comb begin
		case (cfg_q[1:0])
			`TCG_SRC_FAST: itk_src = osc_edge[`TCG_OSC_FAST]; // RULE_01
			`TCG_SRC_EXT: itk_src = ext_edge; // RULE_01
			`TCG_SRC_SLOW: itk_src = osc_edge[`TCG_OSC_SLOW]; // RULE_01
			`TCG_SRC_CAP: itk_src = cap_tick_q; // RULE_01
		endcase
	end

	// capture prescaler: terminal count 2*code+1 gives divide by 2,4,6,8
	assign cap_last = {cfg_q[7:6], 1'b1}; // RULE_03

	// ticks are whole pulses; a config write restarts the prescalers so
	// the first tick after a change is a full period, never a short one
	always_ff @(posedge REF_CLK) begin
		if (RST || cfg_wr) begin
			cap_div_cnt_q <= 3'h0; // RULE_24
			cap_tick_q <= 1'b0;
		end else begin
			cap_tick_q <= 1'b0;
			if (cap_src) begin
				if (cap_div_cnt_q >= cap_last) begin
					cap_div_cnt_q <= 3'h0;
					cap_tick_q <= 1'b1; // RULE_03
				end else begin
					cap_div_cnt_q <= cap_div_cnt_q + 3'h1;
				end
			end
		end
	end

	// interval prescaler: terminal count equals the code, divide by 1..4
	always_ff @(posedge REF_CLK) begin
		if (RST || cfg_wr) begin
			itk_div_cnt_q <= 2'h0; // RULE_24
			itk_tick_q <= 1'b0;
		end else begin
			itk_tick_q <= 1'b0;
			if (itk_src) begin
				if (itk_div_cnt_q >= cfg_q[3:2]) begin
					itk_div_cnt_q <= 2'h0;
					itk_tick_q <= 1'b1; // RULE_02
				end else begin
					itk_div_cnt_q <= itk_div_cnt_q + 2'h1;
				end
			end
		end
	end

	// interval down counter: period is reload plus one ticks
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ival_cnt_q <= `TCG_RLD_RST;
			irq_q <= 1'b0;
		end else begin
			irq_q <= 1'b0;
			if (itk_tick_q) begin
				if (ival_cnt_q == 12'h000) begin
					ival_cnt_q <= reload_q; // RULE_07
					irq_q <= 1'b1; // RULE_08
				end else begin
					ival_cnt_q <= ival_cnt_q - 12'h001; // RULE_06
				end
			end
		end
	end

	// timebase counts capture ticks, so it scales with the capture rate
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			tb_cnt_q <= 12'h000;
			tb_tick_q <= 1'b0;
		end else begin
			tb_tick_q <= 1'b0;
			if (cap_tick_q) begin
				if (tb_cnt_q == `TCG_TB_LAST) begin
					tb_cnt_q <= 12'h000;
					tb_tick_q <= 1'b1; // RULE_11
				end else begin
					tb_cnt_q <= tb_cnt_q + 12'h001; // RULE_11
				end
			end
		end
	end

	// fast oscillator around sleep: stop on entry, ready after three slow edges
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			fosc_q <= FOSC_RUN;
			rec_cnt_q <= 2'h0;
			fosc_en_q <= 1'b1;
			fosc_rdy_q <= 1'b1;
		end else begin
			unique case (fosc_q)
				FOSC_RUN: begin
					if (SLEEP_REQ) begin
						fosc_q <= FOSC_STOPPED;
						fosc_en_q <= 1'b0; // RULE_21
						fosc_rdy_q <= 1'b0;
					end
				end
				FOSC_STOPPED: begin
					// wake restarts the oscillator at once
					if (!SLEEP_REQ) begin
						fosc_q <= FOSC_RECOVER;
						fosc_en_q <= 1'b1; // RULE_21
						rec_cnt_q <= 2'h0;
					end
				end
				FOSC_RECOVER: begin
					// a new sleep before recovery ends stops it again
					if (SLEEP_REQ) begin
						fosc_q <= FOSC_STOPPED;
						fosc_en_q <= 1'b0;
					end else if (osc_edge[`TCG_OSC_SLOW]) begin
						if (rec_cnt_q == `TCG_RECOVER_LAST) begin
							fosc_q <= FOSC_RUN;
							fosc_rdy_q <= 1'b1; // RULE_22
						end else begin
							rec_cnt_q <= rec_cnt_q + 2'h1; // RULE_22
						end
					end
				end
			endcase
		end
	end

	// outputs, all taken from flops
	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign CAPTURE_TICK = cap_tick_q;
	assign INTERVAL_TICK = itk_tick_q;
	assign TIMEBASE_TICK = tb_tick_q;
	assign INTERVAL_IRQ = irq_q;
	assign CPU_CLK_SEL = cpu_sel_q;
	assign XTAL_EN = xtal_en_q;
	assign FAST_OSC_EN = fosc_en_q;
	assign FAST_OSC_READY = fosc_rdy_q;
	assign FAST_TRIM_OFFSET = ftrim_q[7:5];
	assign FAST_TRIM_GAIN = ftrim_q[4:0];
	assign XTAL_GM = xgm_q;
	assign XTAL_TEST_MODE = xmode_q;
	assign SLOW_LOW_POWER = slow_lp_q;
	assign SLOW_BIAS = slow_bias_q;
	assign SLOW_FREQ_TRIM = slow_freq_q;

endmodule

/* tcg_top_chk.sv */
// Purpose: port checks of the timer clock block
// Assumes: one clock domain, synchronous reset
// Notes: bound to tcg_top at the foot of this file
`timescale 1ns/100ps
module tcg_top_chk (
	input wire logic REF_CLK, // clock
	input wire logic RST, // reset
	input wire logic PSEL, // select
	input wire logic PENABLE, // access
	input wire logic PWRITE, // write
	input wire logic [7:0] PADDR, // address
	input wire logic [31:0] PWDATA, // data
	input wire logic PREADY, // ready
	input wire logic PSLVERR, // error
	input wire logic SLEEP_REQ, // sleep
	input wire logic CAPTURE_TICK, // capture
	input wire logic INTERVAL_TICK, // tick
	input wire logic INTERVAL_IRQ, // irq
	input wire logic CPU_CLK_SEL, // cpu select
	input wire logic FAST_OSC_EN, // osc enable
	input wire logic FAST_OSC_READY, // osc ready
	input wire logic [2:0] XTAL_GM, // gm
	input wire logic XTAL_TEST_MODE, // mode
	input wire logic [1:0] SLOW_BIAS // bias
);
	logic [7:0] wd_q; // write data one cycle back
	logic stop_q; // last config write stopped capture
	logic [2:0] quiet_q; // cycles since that write
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// accepted write
	sequence wr_s;
		PSEL && PENABLE && PREADY && PWRITE;
	endsequence
	// setup cycle
	sequence setup_s;
		PSEL && !PENABLE;
	endsequence
	// a pulse may still sit in the pipeline just after a write, hence the quiet count
	always_ff @(posedge REF_CLK) begin
		wd_q <= PWDATA[7:0];
		if (RST) begin
			stop_q <= 1'b0;
			quiet_q <= 3'h0;
		end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR[7:2] == 6'h31) begin
			stop_q <= PWDATA[5:4] == 2'h3;
			quiet_q <= 3'h0;
		end else if (quiet_q != 3'h7) begin
			quiet_q <= quiet_q + 3'h1;
		end
	end
	apb_ready_a: assert property (setup_s |=> PREADY)
		else $error("no ready");
	unmapped_err_a: assert property (setup_s ##0 PADDR[7:2] == 6'h33 |=> PSLVERR && PREADY)
		else $error("no error");
	xtal_trim_a: assert property (wr_s ##0 PADDR[7:2] == 6'h35 |=> {XTAL_GM, XTAL_TEST_MODE} == {wd_q[4:2], wd_q[0]})
		else $error("bad xtal trim");
	slow_bias_a: assert property (wr_s ##0 PADDR[7:2] == 6'h36 && PWDATA[5:4] != 2'h2 |=> SLOW_BIAS == wd_q[5:4])
		else $error("bad bias");
	bias_hold_a: assert property (wr_s ##0 PADDR[7:2] == 6'h36 && PWDATA[5:4] == 2'h2 |=> $stable(SLOW_BIAS))
		else $error("barred bias taken");
	sleep_force_a: assert property (SLEEP_REQ [*2] |-> !CPU_CLK_SEL && !FAST_OSC_EN && !FAST_OSC_READY)
		else $error("sleep not forced");
	wake_en_a: assert property ($fell(SLEEP_REQ) && !$past(RST) |-> ##1 FAST_OSC_EN && !FAST_OSC_READY)
		else $error("bad wake");
	irq_cause_a: assert property (INTERVAL_IRQ |-> $past(INTERVAL_TICK))
		else $error("irq without tick");
	cap_stop_a: assert property (stop_q && quiet_q > 3'h3 |-> !CAPTURE_TICK)
		else $error("stopped capture ticks");
endmodule
bind tcg_top tcg_top_chk i_chk (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP_REQ(SLEEP_REQ),
	.CAPTURE_TICK(CAPTURE_TICK), .INTERVAL_TICK(INTERVAL_TICK), .INTERVAL_IRQ(INTERVAL_IRQ),
	.CPU_CLK_SEL(CPU_CLK_SEL), .FAST_OSC_EN(FAST_OSC_EN), .FAST_OSC_READY(FAST_OSC_READY),
	.XTAL_GM(XTAL_GM), .XTAL_TEST_MODE(XTAL_TEST_MODE), .SLOW_BIAS(SLOW_BIAS));

/* tcg_top_test.sv */
// Purpose: self-checking bench of the timer clock block
// Assumes: oscillators modelled as short fixed periods of REF_CLK
// Notes: gaps in cycles scale with those periods (fast 10, slow 40, xtal 8, pin 14)
`timescale 1ns/100ps
module tcg_top_test import tcg_pkg::*;;
	typedef struct {logic [7:0] a; logic [7:0] wd; logic [7:0] rd; logic er;} tcg_reg_row_t;
	typedef struct {logic [7:0] io; logic [7:0] cfg; int cg; int ig;} tcg_clk_row_t;
	logic REF_CLK = 1'b0, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SLEEP_REQ;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA, r;
	logic FAST_OSC_IN, SLOW_OSC_IN, XTAL_OSC_IN, EXT_CLK_PIN, e;
	logic CAPTURE_TICK, INTERVAL_TICK, TIMEBASE_TICK, INTERVAL_IRQ, CPU_CLK_SEL, XTAL_EN;
	logic FAST_OSC_EN, FAST_OSC_READY, XTAL_TEST_MODE, SLOW_LOW_POWER;
	logic [2:0] FAST_TRIM_OFFSET, XTAL_GM;
	logic [4:0] FAST_TRIM_GAIN;
	logic [1:0] SLOW_BIAS;
	logic [3:0] SLOW_FREQ_TRIM;
	int fail_count = 0; // mismatches
	int n_checks = 0; // comparisons
	int osc_cnt = 0; // oscillator phase
	int g, i; // measured gap, loop index
	// write then read back the trim, reload low and high, and select registers, then an unmapped address
	tcg_reg_row_t regs[10] = '{
		'{8'hd0, 8'hff, 8'hff, 1'b0},
		'{8'hd4, 8'hef, 8'h0d, 1'b0},
		'{8'hd8, 8'hff, 8'hbf, 1'b0},
		'{8'hd8, 8'ha5, 8'hb5, 1'b0},
		'{8'hd8, 8'h12, 8'h12, 1'b0},
		'{8'he0, 8'hab, 8'hab, 1'b0},
		'{8'he4, 8'hf0, 8'h00, 1'b0},
		'{8'he0, 8'h00, 8'h00, 1'b0},
		'{8'hc0, 8'hff, 8'h01, 1'b0},
		'{8'hcc, 8'h5a, 8'h00, 1'b1}};
	// clock selections with expected pulse gaps
	tcg_clk_row_t clks[6] = '{
		'{8'h00, 8'h8f, 60, 240},
		'{8'h00, 8'h00, 20, 10},
		'{8'h00, 8'h55, 56, 28},
		'{8'h08, 8'h55, 32, 16},
		'{8'h00, 8'ha6, 240, 80},
		'{8'h00, 8'hcb, 80, 240}};
	tcg_top i_tcg_top (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.FAST_OSC_IN(FAST_OSC_IN), .SLOW_OSC_IN(SLOW_OSC_IN), .XTAL_OSC_IN(XTAL_OSC_IN),
		.EXT_CLK_PIN(EXT_CLK_PIN), .SLEEP_REQ(SLEEP_REQ), .CAPTURE_TICK(CAPTURE_TICK),
		.INTERVAL_TICK(INTERVAL_TICK), .TIMEBASE_TICK(TIMEBASE_TICK), .INTERVAL_IRQ(INTERVAL_IRQ),
		.CPU_CLK_SEL(CPU_CLK_SEL), .XTAL_EN(XTAL_EN), .FAST_OSC_EN(FAST_OSC_EN),
		.FAST_OSC_READY(FAST_OSC_READY), .FAST_TRIM_OFFSET(FAST_TRIM_OFFSET),
		.FAST_TRIM_GAIN(FAST_TRIM_GAIN), .XTAL_GM(XTAL_GM), .XTAL_TEST_MODE(XTAL_TEST_MODE),
		.SLOW_LOW_POWER(SLOW_LOW_POWER), .SLOW_BIAS(SLOW_BIAS), .SLOW_FREQ_TRIM(SLOW_FREQ_TRIM));
	// 250 MHz clock
	always #2 REF_CLK = ~REF_CLK;
	// oscillators locked to REF_CLK so that gaps are exact
	always @(posedge REF_CLK) begin
		osc_cnt <= osc_cnt + 1;
		FAST_OSC_IN <= osc_cnt % 10 < 5;
		SLOW_OSC_IN <= osc_cnt % 40 < 20;
		XTAL_OSC_IN <= osc_cnt % 8 < 4;
		EXT_CLK_PIN <= osc_cnt % 14 < 7;
	end
	// verdict and end of run
	task test_done;
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// compare one value
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("Error %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask
	// one apb transfer, then an idle cycle
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] rd, output logic er);
		int k;
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= {24'h00_0000, d};
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		k = 0;
		do begin
			@(posedge REF_CLK);
			k++;
		end while (PREADY !== 1'b1 && k < 20);
		rd = PRDATA;
		er = PSLVERR;
		if (k == 20) begin
			fail_count++;
			test_done;
		end
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge REF_CLK);
	endtask
	// pulse picked by number: capture, interval, irq
	function automatic logic pick(int s);
		return s == 0 ? CAPTURE_TICK : s == 1 ? INTERVAL_TICK : INTERVAL_IRQ;
	endfunction
	// cycles between two pulses; 0 when none arrives
	task gap(input int s, output int n);
		int k;
		n = 0;
		for (k = 0; k < 2000 && pick(s) !== 1'b1; k++)
			@(posedge REF_CLK);
		if (k < 2000) begin
			@(posedge REF_CLK);
			for (n = 1; n < 600 && pick(s) !== 1'b1; n++)
				@(posedge REF_CLK);
			if (n == 600) begin
				fail_count++;
				test_done;
			end
		end
	endtask
	// hang guard
	initial begin
		#400000;
		fail_count++;
		test_done;
	end
	// main sequence
	initial begin
		RST = 1'b1;
		{PSEL, PENABLE, PWRITE, SLEEP_REQ} = 4'h0;
		PADDR = 8'h00;
		PWDATA = 32'h0000_0000;
		repeat (4) @(posedge REF_CLK);
		RST <= 1'b0;
		@(posedge REF_CLK);
		apb(1'b0, 8'hc4, 8'h00, r, e);
		chk(r, 8'h8f);
		chk({CPU_CLK_SEL, XTAL_EN, FAST_OSC_EN, FAST_OSC_READY}, 4'h3);
		foreach (regs[j]) begin
			apb(1'b1, regs[j].a, regs[j].wd, r, e);
			chk(e, regs[j].er);
			apb(1'b0, regs[j].a, 8'h00, r, e);
			chk(r, {24'h00_0000, regs[j].rd});
		end
		chk({FAST_TRIM_OFFSET, FAST_TRIM_GAIN}, 8'hff);
		chk({XTAL_GM, XTAL_TEST_MODE}, 4'h7);
		chk({SLOW_LOW_POWER, SLOW_BIAS, SLOW_FREQ_TRIM}, 7'h12);
		foreach (clks[j]) begin
			apb(1'b1, 8'hc8, clks[j].io, r, e);
			apb(1'b1, 8'hc4, clks[j].cfg, r, e);
			repeat (5) @(posedge REF_CLK);
			chk(XTAL_EN, clks[j].io[3]);
			gap(0, g);
			chk(g, clks[j].cg);
			gap(1, g);
			chk(g, clks[j].ig);
		end
		// reload values 0, 3, 6 at one tick per 10 cycles
		apb(1'b1, 8'hc4, 8'h00, r, e);
		for (i = 0; i < 9; i += 3) begin
			apb(1'b1, 8'he0, 8'(i), r, e);
			apb(1'b0, 8'he0, 8'h00, r, e);
			chk(r, i);
			gap(2, g);
			chk(g, (i + 1) * 10);
		end
		// sleep forces the internal clock; selection writes are ignored meanwhile
		SLEEP_REQ <= 1'b1;
		repeat (2) @(posedge REF_CLK);
		chk({CPU_CLK_SEL, FAST_OSC_EN, FAST_OSC_READY}, 3'h0);
		apb(1'b1, 8'hc0, 8'h01, r, e);
		chk(CPU_CLK_SEL, 1'b0);
		SLEEP_REQ <= 1'b0;
		repeat (80) @(posedge REF_CLK);
		chk({FAST_OSC_EN, FAST_OSC_READY}, 2'h2);
		for (i = 0; i < 60 && FAST_OSC_READY !== 1'b1; i++)
			@(posedge REF_CLK);
		chk({FAST_OSC_READY, CPU_CLK_SEL}, 2'h2);
		// back on external after wake: crystal on, settle, then reselect
		apb(1'b1, 8'hc8, 8'h08, r, e);
		repeat (20) @(posedge REF_CLK);
		apb(1'b1, 8'hc0, 8'h01, r, e);
		chk(CPU_CLK_SEL, 1'b1);
		// mid-run reset must drop the select and the crystal enable again
		RST <= 1'b1;
		repeat (4) @(posedge REF_CLK);
		RST <= 1'b0;
		@(posedge REF_CLK);
		chk({CPU_CLK_SEL, XTAL_EN, FAST_OSC_EN, FAST_OSC_READY}, 4'h3);
		// timebase is 1024 us of 4 MHz capture ticks: crystal over 2, 16 cycles each
		apb(1'b1, 8'hc8, 8'h08, r, e);
		apb(1'b1, 8'hc4, 8'h10, r, e);
		g = 0;
		for (i = 0; i < 70000 && TIMEBASE_TICK !== 1'b1; i++) begin
			@(posedge REF_CLK);
			if (CAPTURE_TICK === 1'b1)
				g++;
		end
		chk(g, 4096);
		// capture stopped last, since it may not be left again
		apb(1'b1, 8'hc4, 8'h3e, r, e);
		repeat (5) @(posedge REF_CLK);
		gap(0, g);
		chk(g, 0);
		gap(1, g);
		chk(g, 160);
		test_done;
	end
endmodule
